// >>> hdl/pwp_pkg.sv
// Shared constants, types and helpers of the peripheral write-protect controller
`default_nettype none
package pwp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus widths
  localparam int PWP_DATA_W = 32;
  localparam int PWP_ADDR_W = 16;
  localparam int PWP_STRB_W = 4;
  localparam int PWP_PROT_W = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Address map: each peripheral on the bridge owns one slot
  localparam int PWP_SLOT_LSB = 10;
  localparam int PWP_SLOT_W   = 3;
  localparam int PWP_NSLOT    = 8;
  localparam int PWP_OFS_W    = 10;
  localparam logic [PWP_SLOT_W-1:0] PWP_SELF_SLOT = 3'h0;
  localparam logic [PWP_OFS_W-1:0]  PWP_OFS_CLEAR = 10'h000;
  localparam logic [PWP_OFS_W-1:0]  PWP_OFS_SET   = 10'h004;

  ////////////////////////////////////////////////////////////////////////////////
  // Protection vector fields and reset values
  localparam int PWP_BIT_POWER_MANAGER  = 1;
  localparam int PWP_BIT_SYSTEM_CONTROL = 2;
  localparam int PWP_BIT_CLOCK_GEN      = 3;
  localparam int PWP_BIT_WATCHDOG       = 4;
  localparam int PWP_BIT_CALENDAR       = 5;
  localparam int PWP_BIT_EXT_IRQ        = 6;
  localparam logic [PWP_DATA_W-1:0] PWP_PROT_RESET = 32'h00000000;
  // Bits 6..1 only; bit 0 and bits 31..7 are reserved and read zero
  localparam logic [PWP_DATA_W-1:0] PWP_VALID_MASK = 32'h0000007e;

  // Bus clocks of the three controllers: first two on, third off
  localparam int PWP_NCTRL = 3;
  localparam logic [PWP_NCTRL-1:0] PWP_CLK_EN_RESET = 3'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states, Gray along idle -> forward -> done
  typedef enum logic [1:0]
  {
    PWP_IDLE = 2'h0,
    PWP_FWD  = 2'h1,
    PWP_DONE = 2'h3
  } pwp_state_t;

  // Merged address/data request: one cycle carries everything
  typedef struct packed
  {
    logic                  valid;
    logic [PWP_ADDR_W-1:0] addr;
    logic                  write;
    logic [PWP_DATA_W-1:0] wdata;
    logic [PWP_STRB_W-1:0] strb;
    logic [PWP_PROT_W-1:0] prot;
    logic                  debug;
  } pwp_req_t;

  typedef struct packed
  {
    logic                  ready;
    logic                  slverr;
    logic [PWP_DATA_W-1:0] rdata;
  } pwp_rsp_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-lane strobes expanded to a bit mask
  function automatic logic [PWP_DATA_W-1:0] pwp_lane_mask(input logic [PWP_STRB_W-1:0] strb);
    logic [PWP_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < PWP_STRB_W; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

endpackage
`default_nettype wire

// >>> hdl/pwp_prot_vec.sv
// Protection vector with set/clear access and double-operation detection
`timescale 1ns/1ns
`default_nettype none
module pwp_prot_vec
  import pwp_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  wr_set,
  input  wire logic                  wr_clr,
  input  wire logic [PWP_DATA_W-1:0] wdata,
  input  wire logic [PWP_STRB_W-1:0] strb,
  output logic      [PWP_DATA_W-1:0] vec,
  output logic                       dbl_err
);

  logic [PWP_DATA_W-1:0] ones;
  logic [PWP_DATA_W-1:0] next_vec;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // Zeros and unselected lanes never touch the state
    ones     = wdata & pwp_lane_mask(strb) & PWP_VALID_MASK;
    dbl_err  = 1'b0;
    next_vec = vec;
    if (wr_set)
    begin
      dbl_err = |(ones & vec);
    end
    else if (wr_clr)
    begin
      dbl_err = |(ones & ~vec);
    end
    // A faulty double operation is discarded whole so program flow errors leave no trace
    if (wr_set && !dbl_err)
    begin
      next_vec = vec | ones;
    end
    else if (wr_clr && !dbl_err)
    begin
      next_vec = vec & ~ones;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      vec <= PWP_PROT_RESET;
    end
    else
    begin
      vec <= next_vec;
    end
  end

endmodule // pwp_prot_vec
`default_nettype wire

// >>> hdl/pwp_guard.sv
// Write-protect guard sitting between the bridge and its peripherals
`timescale 1ns/1ns
`default_nettype none
module pwp_guard
  import pwp_pkg::*;
#(
  parameter int NSLOT = PWP_NSLOT
)
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire pwp_req_t             up_req,
  output pwp_rsp_t                  up_rsp,
  output pwp_req_t                  dn_req,
  output logic      [NSLOT-1:0]     dn_sel,
  input  wire pwp_rsp_t             dn_rsp,
  output logic      [PWP_DATA_W-1:0] prot_vec,
  input  wire logic                 clk_en_wr,
  input  wire logic [PWP_NCTRL-1:0] clk_en_val,
  output logic      [PWP_NCTRL-1:0] guard_clk_en
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of the incoming request

  pwp_state_t            state;
  pwp_state_t            next_state;
  logic [PWP_SLOT_W-1:0] slot;
  logic [PWP_OFS_W-1:0]  ofs;
  logic                  take;
  logic                  local_hit;
  logic                  hit_set;
  logic                  hit_clr;
  logic                  blocked;
  logic                  wr_set;
  logic                  wr_clr;
  logic                  dbl_err;
  logic [PWP_DATA_W-1:0] vec;

  assign slot      = up_req.addr[PWP_SLOT_LSB +: PWP_SLOT_W];
  assign ofs       = up_req.addr[PWP_OFS_W-1:0];
  assign take      = (state == PWP_IDLE) && up_req.valid;
  assign local_hit = (slot == PWP_SELF_SLOT);
  assign hit_set   = local_hit && (ofs == PWP_OFS_SET);
  assign hit_clr   = local_hit && (ofs == PWP_OFS_CLEAR);

  // Only writes are gated, and the debugger is never gated
  assign blocked = up_req.write && !up_req.debug && vec[slot];

  assign wr_set = take && up_req.write && hit_set;
  assign wr_clr = take && up_req.write && hit_clr;

  ////////////////////////////////////////////////////////////////////////////////
  // Request class: own register, unmapped own offset, blocked or forwarded

  typedef enum logic [1:0]
  {
    PWP_KIND_LOCAL    = 2'h0,
    PWP_KIND_UNMAPPED = 2'h1,
    PWP_KIND_BLOCKED  = 2'h2,
    PWP_KIND_FORWARD  = 2'h3
  } pwp_kind_t;

  pwp_kind_t kind;

  // The guard's own slot is decoded before protection, so it can never lock itself out
  always_comb
  begin
    if (local_hit && (hit_set || hit_clr))
    begin
      kind = PWP_KIND_LOCAL;
    end
    else if (local_hit)
    begin
      kind = PWP_KIND_UNMAPPED;
    end
    else if (blocked)
    begin
      kind = PWP_KIND_BLOCKED;
    end
    else
    begin
      kind = PWP_KIND_FORWARD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers of the local, refused and forwarded paths

  // Slot numbers at or above NSLOT select nothing rather than wrapping onto a real slot
  function automatic logic [NSLOT-1:0] slot_select(input logic [PWP_SLOT_W-1:0] s);
    logic [NSLOT-1:0] sel;
    sel = '0;
    for (int i = 0; i < NSLOT; i++)
    begin
      if (s == PWP_SLOT_W'(i))
      begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction

  // Reads honour byte lanes as writes do; unstrobed lanes return zero
  function automatic logic [PWP_DATA_W-1:0] lane_data(input logic [PWP_DATA_W-1:0] d,
                                                      input logic [PWP_STRB_W-1:0] s);
    return d & pwp_lane_mask(s);
  endfunction

  // Answer of every refused request: one-cycle ready with the error flag
  function automatic pwp_rsp_t err_rsp();
    pwp_rsp_t r;
    r        = '0;
    r.ready  = 1'b1;
    r.slverr = 1'b1;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Protection state

  pwp_prot_vec u_prot_vec
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .wr_set  (wr_set),
    .wr_clr  (wr_clr),
    .wdata   (up_req.wdata),
    .strb    (up_req.strb),
    .vec     (vec),
    .dbl_err (dbl_err)
  );

  // The vector flop inside the submodule drives this output directly
  assign prot_vec = vec;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  pwp_req_t          next_dn_req;
  logic [NSLOT-1:0]  next_dn_sel;

  always_comb
  begin
    next_state  = state;
    next_dn_req = dn_req;
    next_dn_sel = dn_sel;
    case (state)
      PWP_IDLE:
      begin
        if (up_req.valid)
        begin
          if (kind == PWP_KIND_FORWARD)
          begin
            // Address, data and strobes leave together in one cycle
            next_dn_req       = up_req;
            next_dn_req.valid = 1'b1;
            next_dn_sel       = slot_select(slot);
            next_state        = PWP_FWD;
          end
          else
          begin
            // Own and refused requests answer in one cycle
            next_state = PWP_DONE;
          end
        end
      end
      PWP_FWD:
      begin
        // Peripheral may stretch the transfer with wait states
        if (dn_rsp.ready)
        begin
          next_dn_req.valid  = 1'b0;
          next_dn_sel        = '0;
          next_state         = PWP_DONE;
        end
      end
      PWP_DONE:
      begin
        // Turnaround cycle lets the source drop its request first
        next_state = PWP_IDLE;
      end
      default:
      begin
        next_state        = PWP_IDLE;
        next_dn_req.valid = 1'b0;
        next_dn_sel       = '0;
      end
    endcase
  end

  // No sleep input: the guard runs whenever its clock runs
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state  <= PWP_IDLE;
      dn_req <= '0;
      dn_sel <= '0;
    end
    else
    begin
      state  <= next_state;
      dn_req <= next_dn_req;
      dn_sel <= next_dn_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Upstream answer: a one-cycle pulse with its error flag and read data

  pwp_rsp_t next_up_rsp;

  always_comb
  begin
    next_up_rsp = '0;
    if ((state == PWP_IDLE) && up_req.valid)
    begin
      case (kind)
        PWP_KIND_LOCAL:
        begin
          // Own registers answer at once, no wait states
          next_up_rsp.ready = 1'b1;
          if (up_req.write)
          begin
            next_up_rsp.slverr = dbl_err;
          end
          else
          begin
            next_up_rsp.rdata = lane_data(vec, up_req.strb);
          end
        end
        PWP_KIND_UNMAPPED:
        begin
          // Unmapped own offsets answer an error and change nothing
          next_up_rsp = err_rsp();
        end
        PWP_KIND_BLOCKED:
        begin
          // Nothing reaches the peripheral; the error alone goes back
          next_up_rsp = err_rsp();
        end
        PWP_KIND_FORWARD:
        begin
          // The answer comes later, from the peripheral
          next_up_rsp = '0;
        end
        default:
        begin
          next_up_rsp = '0;
        end
      endcase
    end
    else if ((state == PWP_FWD) && dn_rsp.ready)
    begin
      next_up_rsp.ready  = 1'b1;
      next_up_rsp.slverr = dn_rsp.slverr;
      next_up_rsp.rdata  = dn_req.write ? '0 : lane_data(dn_rsp.rdata, dn_req.strb);
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      up_rsp <= '0;
    end
    else
    begin
      up_rsp <= next_up_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus clock enables of the guard instances

  logic [PWP_NCTRL-1:0] next_guard_clk_en;

  always_comb
  begin
    next_guard_clk_en = guard_clk_en;
    if (clk_en_wr)
    begin
      next_guard_clk_en = clk_en_val;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      guard_clk_en <= PWP_CLK_EN_RESET;
    end
    else
    begin
      guard_clk_en <= next_guard_clk_en;
    end
  end

endmodule // pwp_guard
`default_nettype wire

// >>> tb/pwp_guard_monitor.sv
// Checker for the write-protect guard ports
`timescale 1ns/1ns
`default_nettype none
module pwp_guard_monitor
  import pwp_pkg::*;
#(
  parameter int NSLOT = PWP_NSLOT
)
(
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire pwp_req_t              up_req,
  input wire pwp_rsp_t              up_rsp,
  input wire pwp_req_t              dn_req,
  input wire logic [NSLOT-1:0]      dn_sel,
  input wire pwp_rsp_t              dn_rsp,
  input wire logic [PWP_DATA_W-1:0] prot_vec,
  input wire logic                  clk_en_wr,
  input wire logic [PWP_NCTRL-1:0]  clk_en_val,
  input wire logic [PWP_NCTRL-1:0]  guard_clk_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  rsv_zero_a: assert property ((prot_vec & ~PWP_VALID_MASK) == '0)
    else $error("reserved protection bits set");
  rdy_pulse_a: assert property (up_rsp.ready |=> !up_rsp.ready)
    else $error("ready longer than one cycle");
  vec_hold_a: assert property ($changed(prot_vec) |-> up_rsp.ready && !up_rsp.slverr)
    else $error("protection changed without a clean write");
  fwd_answer_a: assert property (dn_req.valid && dn_rsp.ready |=>
    up_rsp.ready && up_rsp.slverr == $past(dn_rsp.slverr))
    else $error("peripheral answer not forwarded");
  merged_cycle_a: assert property ($rose(dn_req.valid) |->
    dn_req.addr == $past(up_req.addr) && dn_req.wdata == $past(up_req.wdata))
    else $error("forwarded address or data differ");
  sel_onehot_a: assert property (dn_req.valid |-> $onehot(dn_sel) && dn_sel[dn_req.addr[12:10]])
    else $error("slot select wrong");
  no_bypass_a: assert property ($rose(dn_req.valid) && dn_req.write && !dn_req.debug |->
    (prot_vec[NSLOT-1:0] & dn_sel) == '0)
    else $error("write to protected slot forwarded");
  clk_load_a: assert property (clk_en_wr |=> guard_clk_en == $past(clk_en_val))
    else $error("clock enables not loaded");
  lane_mask_a: assert property (up_rsp.ready && !up_req.strb[0] |-> up_rsp.rdata[7:0] == 8'h00)
    else $error("unstrobed lane not zero");
  cover property (up_rsp.ready && up_rsp.slverr);
  cover property (dn_req.valid && dn_rsp.ready);
  cover property (clk_en_wr);
endmodule // pwp_guard_monitor

bind pwp_guard pwp_guard_monitor #(.NSLOT(NSLOT)) u_pwp_guard_monitor (
  .mclk(mclk), .resetn(resetn), .up_req(up_req), .up_rsp(up_rsp),
  .dn_req(dn_req), .dn_sel(dn_sel), .dn_rsp(dn_rsp), .prot_vec(prot_vec),
  .clk_en_wr(clk_en_wr), .clk_en_val(clk_en_val), .guard_clk_en(guard_clk_en));
`default_nettype wire

// >>> tb/pwp_periph_model.sv
// Peripheral model on the guard's downstream bus
`timescale 1ns/1ns
`default_nettype none
module pwp_periph_model
  import pwp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire pwp_req_t   dn_req,
  input  wire logic [7:0] dn_sel,
  input  wire logic [3:0] wait_cyc,
  output pwp_rsp_t        dn_rsp
);
  logic [PWP_DATA_W-1:0] mem [8];
  logic [3:0]            cnt;
  logic [2:0]            s;
  assign s = dn_req.addr[12:10];
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dn_rsp <= '0;
      cnt <= 4'h0;
      for (int i = 0; i < 8; i++)
        mem[i] <= '0;
    end
    else if (dn_req.valid && |dn_sel && !dn_rsp.ready && cnt >= wait_cyc)
    begin
      // Offset 0x3fc stands for a register that always errors
      dn_rsp.ready <= 1'b1;
      dn_rsp.slverr <= dn_req.addr[9:0] == 10'h3fc;
      dn_rsp.rdata <= dn_req.write ? ~dn_rsp.rdata : mem[s];
      for (int i = 0; i < 4; i++)
        if (dn_req.write && dn_req.strb[i])
          mem[s][i*8 +: 8] <= dn_req.wdata[i*8 +: 8];
    end
    else
    begin
      // Idle data toggles so a stale value is never mistaken for an answer
      dn_rsp.ready <= 1'b0;
      dn_rsp.slverr <= 1'b0;
      dn_rsp.rdata <= ~dn_rsp.rdata;
      cnt <= (dn_req.valid && !dn_rsp.ready) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // pwp_periph_model
`default_nettype wire

// >>> tb/pwp_guard_tb.sv
// Self-checking bench for the write-protect guard
`timescale 1ns/1ns
`default_nettype none
module pwp_guard_tb;
  import pwp_pkg::*;
  localparam logic [15:0] CLR = 16'h0000;
  localparam logic [15:0] SET = 16'h0004;
  localparam logic [15:0] P2 = 16'h0800;
  logic mclk = 1'b0;
  logic resetn, clk_en_wr, er;
  logic [2:0] clk_en_val, guard_clk_en;
  logic [3:0] wait_cyc;
  logic [7:0] dn_sel;
  logic [31:0] prot_vec, rd;
  pwp_req_t up_req, dn_req;
  pwp_rsp_t up_rsp, dn_rsp;
  int err_count, n_compared, cyc;
  pwp_guard u_pwp_guard (.mclk(mclk), .resetn(resetn), .up_req(up_req), .up_rsp(up_rsp),
    .dn_req(dn_req), .dn_sel(dn_sel), .dn_rsp(dn_rsp), .prot_vec(prot_vec),
    .clk_en_wr(clk_en_wr), .clk_en_val(clk_en_val), .guard_clk_en(guard_clk_en));
  pwp_periph_model u_pwp_periph_model (.mclk(mclk), .resetn(resetn), .dn_req(dn_req),
    .dn_sel(dn_sel), .wait_cyc(wait_cyc), .dn_rsp(dn_rsp));
  always #25 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request stays up through the edge that samples ready, then drops
  task automatic acc(input logic [15:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, input logic dbg);
    int n;
    @(negedge mclk);
    up_req = '{valid:1'b1, addr:a, write:w, wdata:d, strb:s, prot:3'h0, debug:dbg};
    n = 0;
    while (up_rsp.ready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    chk("ready", 32'h1, {31'h0, up_rsp.ready});
    rd = up_rsp.rdata;
    er = up_rsp.slverr;
    @(negedge mclk);
    up_req.valid = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic dbg, input logic e);
    acc(a, 1'b1, d, s, dbg);
    chk("slverr", {31'h0, e}, {31'h0, er});
  endtask
  task automatic rdc(input logic [15:0] a, input logic [3:0] s, input logic [31:0] x);
    acc(a, 1'b0, 32'h0, s, 1'b0);
    chk("rdata", x, rd);
  endtask
  ////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    up_req = '0;
    clk_en_wr = 1'b0;
    clk_en_val = 3'h0;
    wait_cyc = 4'h3;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    chk("clk_en", 32'h3, {29'h0, guard_clk_en});
    rdc(CLR, 4'hf, 32'h0);
    wr(P2, 32'h11223344, 4'hf, 1'b0, 1'b0);
    rdc(P2, 4'h3, 32'h00003344);
    rdc(P2, 4'hc, 32'h11220000);
    wait_cyc = 4'h0;
    wr(SET, 32'h8, 4'he, 1'b0, 1'b0);
    chk("prot_vec", 32'h0, prot_vec);
    wr(SET, 32'h4, 4'hf, 1'b0, 1'b0);
    rdc(CLR, 4'hf, 32'h4);
    rdc(SET, 4'hf, 32'h4);
    rdc(CLR, 4'h1, 32'h4);
    wr(SET, 32'h4, 4'hf, 1'b0, 1'b1);
    wr(P2, 32'h0, 4'hf, 1'b0, 1'b1);
    rdc(P2, 4'hf, 32'h11223344);
    wr(P2, 32'h55, 4'h1, 1'b1, 1'b0);
    rdc(P2, 4'hf, 32'h11223355);
    wr(CLR, 32'h0, 4'hf, 1'b0, 1'b0);
    chk("prot_vec", 32'h4, prot_vec);
    rdc(SET, 4'hf, 32'h4);
    wr(CLR, 32'h4, 4'hf, 1'b0, 1'b0);
    wr(CLR, 32'h4, 4'hf, 1'b0, 1'b1);
    wr(P2, 32'h0, 4'hf, 1'b0, 1'b0);
    wr(16'h17fc, 32'h0, 4'hf, 1'b0, 1'b1);
    wr(16'h0008, 32'h0, 4'hf, 1'b0, 1'b1);
    for (int i = 1; i < 7; i++)
    begin
      wr(SET, 32'h1 << i, 4'hf, 1'b0, 1'b0);
      chk("prot_vec", 32'h1 << i, prot_vec);
      wr(CLR, 32'h1 << i, 4'hf, 1'b0, 1'b0);
    end
    @(negedge mclk);
    clk_en_wr = 1'b1;
    clk_en_val = 3'h4;
    @(negedge mclk);
    clk_en_wr = 1'b0;
    chk("clk_en", 32'h4, {29'h0, guard_clk_en});
    // Mid-run reset must bring protection and clock enables back to their reset values
    wr(SET, 32'h40, 4'h1, 1'b0, 1'b0);
    @(negedge mclk);
    resetn = 1'b0;
    @(negedge mclk);
    resetn = 1'b1;
    chk("prot_vec", 32'h0, prot_vec);
    chk("clk_en", 32'h3, {29'h0, guard_clk_en});
    wrap_up();
  end
endmodule // pwp_guard_tb
`default_nettype wire
